// >>> verilog/ccte_channel.v
// CAN channel core: APB registers, bit timing and error confinement
//
// Notes on behaviour
// - Enabled channel with counter below 96 reports error active.
// - Counter at or above 96 reports error warning.
// - Counter at or above 128 reports error passive.
// - Counter above 255 takes the channel off the bus, bus off.
// - Disabled or sleeping channel reports a separate inactive state.
// - Silent mode never drives the bus: no frames, no acknowledge.
// - Per channel enable bit and a single channel reset action.
// - Prescaler divides the clock into quanta, accepts 1 to 256.
// - Phase segment 1 spans 1 to 8 quanta, segment 2 spans 2 to 8.
// - Propagation segment spans 1 to 8 quanta.
// - Each bit opens with a one quantum sync segment.
// - Segment 1 is phase 1 plus propagation; below 4 is rejected.
// - Segment 2 is phase 2; sampling at the segment 1/2 boundary.
// - Sample instant placed only by the two segment lengths.
// - Out of range fields or rates outside 5k to 1M are refused.
// - Jump width 1 to 4 caps resync lengthening or shortening.
// - Jump width does not enter the nominal bit length.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "ccte_map.vh"

module ccte_channel
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        can_rx,
  output reg         can_tx,
  input  wire        tx_bit,
  input  wire        ack_req,
  input  wire        err_tx,
  input  wire        err_rx,
  input  wire        ok_tx,
  input  wire        ok_rx,
  output reg         rx_bit_q,
  output reg         sample_q,
  output reg         bit_start_q,
  output wire        irq
);

  // ****************************************
  // Timing field checks
  // ****************************************
  // Returns high when a timing word may be taken as the new setting
  function timing_ok;
    input [31:0] w;
    reg   [8:0]  brp;
    reg   [3:0]  prop;
    reg   [3:0]  ph1;
    reg   [3:0]  ph2;
    reg   [2:0]  sjw;
    reg   [4:0]  nq;
    reg   [13:0] cyc;
    begin
      brp  = w[`CCTE_BRP_LSB +: 9];
      prop = w[`CCTE_PROP_LSB +: 4];
      ph1  = w[`CCTE_PH1_LSB +: 4];
      ph2  = w[`CCTE_PH2_LSB +: 4];
      sjw  = w[`CCTE_SJW_LSB +: 3];
      // Sync quantum plus both segments; jump width left out
      nq   = 5'd1 + {1'b0, prop} + {1'b0, ph1} + {1'b0, ph2};
      cyc  = brp * nq;
      timing_ok =
        (brp != 9'd0) && (brp <= `CCTE_BRP_MAX) &&
        (ph1 != 4'd0) && (ph1 <= `CCTE_SEG_MAX) &&
        (ph2 >= `CCTE_PH2_MIN) && (ph2 <= `CCTE_SEG_MAX) &&
        (prop != 4'd0) && (prop <= `CCTE_SEG_MAX) &&
        ({1'b0, prop} + {1'b0, ph1} >= `CCTE_TS1_MIN) &&
        (sjw != 3'd0) && (sjw <= `CCTE_SJW_MAX) &&
        (cyc >= `CCTE_CYC_MIN) && (cyc <= `CCTE_CYC_MAX);
    end
  endfunction

  // ****************************************
  // APB decode
  // ****************************************
  wire acc   = psel & penable;
  wire wr    = acc & pwrite;
  wire hit_c = (paddr == `CCTE_OFS_CTRL);
  wire hit_t = (paddr == `CCTE_OFS_TIMING);
  wire hit_s = (paddr == `CCTE_OFS_STATUS);
  wire hit_i = (paddr == `CCTE_OFS_IRQ_STAT);
  wire hit_x = (paddr == `CCTE_OFS_IRQ_CLR);
  wire hit_e = (paddr == `CCTE_OFS_IRQ_EN);
  wire mapped = hit_c | hit_t | hit_s | hit_i | hit_x | hit_e;

  // Zero wait states; unmapped words answer with an error
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  reg  [3:0]  ctrl_q;
  reg  [31:0] timing_q;
  reg  [2:0]  irq_st_q;
  reg  [2:0]  irq_en_q;
  reg  [8:0]  tec_q;
  reg  [8:0]  rec_q;
  reg         off_q;
  reg  [2:0]  state_q;

  // Reset action is a self-clearing pulse, never stored
  wire chan_rst = wr & hit_c & pwdata[`CCTE_CTRL_RST];
  wire t_wr     = wr & hit_t;
  wire t_rej    = t_wr & ~timing_ok(pwdata);
  wire enabled  = ctrl_q[`CCTE_CTRL_EN];
  wire silent   = ctrl_q[`CCTE_CTRL_SILENT];
  wire sleeping = ctrl_q[`CCTE_CTRL_SLEEP];
  wire running  = enabled & ~sleeping & ~off_q;

  // Control and timing registers; bad timing keeps the old setting
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q   <= 4'h0;
      timing_q <= `CCTE_TIMING_RST;
      irq_en_q <= 3'h0;
    end
    else
    begin
      if (wr & hit_c)
        ctrl_q <= {pwdata[3], 1'b0, pwdata[1:0]};
      if (t_wr & ~t_rej)
        timing_q <= pwdata;
      if (wr & hit_e)
        irq_en_q <= pwdata[2:0];
    end
  end

  // Read mux; the clear register reads as zero
  always @*
  begin
    prdata = 32'h0000_0000;
    if (acc & ~pwrite)
    begin
      if (hit_c)
        prdata = {28'h000_0000, ctrl_q};
      else if (hit_t)
        prdata = timing_q;
      else if (hit_s)
        // Exactly one word: tec [31:23], rec [16:8], off [3], state [2:0]
        prdata = {tec_q, 6'h00, rec_q, 4'h0, off_q, state_q};
      else if (hit_i)
        prdata = {29'h0000_0000, irq_st_q};
      else if (hit_e)
        prdata = {29'h0000_0000, irq_en_q};
    end
  end

  // ****************************************
  // Bus input synchroniser
  // ****************************************
  reg rx_s1_q;
  reg rx_s2_q;
  reg rx_prev_q;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_s1_q   <= 1'b1;
      rx_s2_q   <= 1'b1;
      rx_prev_q <= 1'b1;
    end
    else
    begin
      rx_s1_q   <= can_rx;
      rx_s2_q   <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
    end
  end
  // Recessive to dominant edge drives resynchronisation
  wire fall = rx_prev_q & ~rx_s2_q;

  // ****************************************
  // Bit timing
  // ****************************************
  wire [8:0] brp = timing_q[`CCTE_BRP_LSB +: 9];
  wire [4:0] ts1 = {1'b0, timing_q[`CCTE_PROP_LSB +: 4]}
                 + {1'b0, timing_q[`CCTE_PH1_LSB +: 4]};
  wire [4:0] ts2 = {1'b0, timing_q[`CCTE_PH2_LSB +: 4]};
  wire [4:0] sjw = {2'b00, timing_q[`CCTE_SJW_LSB +: 3]};

  reg  [8:0] pre_q;
  reg  [4:0] tq_q;
  reg  [4:0] samp_q;
  reg  [4:0] end_q;
  reg        edge_q;
  reg        synced_q;

  // One quantum per prescaler wrap
  wire tq_tick = (pre_q == brp - 9'd1);
  wire at_end  = tq_tick & (tq_q == end_q);
  wire at_samp = tq_tick & (tq_q == samp_q);
  wire resync  = tq_tick & (edge_q | fall) & ~synced_q & (tq_q != 5'd0);
  wire early   = (tq_q <= samp_q);
  wire [4:0] err_ph1 = (tq_q < sjw) ? tq_q : sjw;
  wire [4:0] left    = end_q + 5'd1 - tq_q;
  wire [4:0] err_ph2 = (left < sjw) ? left : sjw;

  // Quantum counter; sample point set only by the two segments
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_q       <= 9'h000;
      tq_q        <= 5'h00;
      samp_q      <= 5'h00;
      end_q       <= 5'h00;
      edge_q      <= 1'b0;
      synced_q    <= 1'b0;
      sample_q    <= 1'b0;
      bit_start_q <= 1'b0;
      rx_bit_q    <= 1'b1;
    end
    else if (chan_rst | ~running)
    begin
      pre_q       <= 9'h000;
      tq_q        <= 5'h00;
      samp_q      <= ts1;
      end_q       <= ts1 + ts2;
      edge_q      <= 1'b0;
      synced_q    <= 1'b0;
      sample_q    <= 1'b0;
      bit_start_q <= 1'b0;
      rx_bit_q    <= 1'b1;
    end
    else
    begin
      pre_q       <= tq_tick ? 9'h000 : pre_q + 9'd1;
      sample_q    <= at_samp;
      bit_start_q <= 1'b0;
      // Edges between ticks are held until the next quantum
      if (tq_tick)
        edge_q <= 1'b0;
      else if (fall)
        edge_q <= 1'b1;
      if (at_samp)
        rx_bit_q <= rx_s2_q;
      // Shortening past the current quantum ends the bit at once
      if (at_end | (resync & ~early & (err_ph2 == left)))
      begin
        tq_q        <= 5'h00;
        samp_q      <= ts1;
        end_q       <= ts1 + ts2;
        synced_q    <= 1'b0;
        bit_start_q <= 1'b1;
      end
      else if (tq_tick)
      begin
        tq_q <= tq_q + 5'd1;
        if (resync)
        begin
          synced_q <= 1'b1;
          if (early)
          begin
            samp_q <= samp_q + err_ph1;
            end_q  <= end_q + err_ph1;
          end
          else
            end_q <= end_q - err_ph2;
        end
      end
    end
  end

  // Transmitter stays recessive while silent or off the bus
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      can_tx <= 1'b1;
    else if (~running | silent)
      can_tx <= 1'b1;
    else
      can_tx <= tx_bit & ~ack_req;
  end

  // ****************************************
  // Error counters
  // ****************************************
  wire [9:0] tec_up = {1'b0, tec_q} + 10'd8;
  wire       count  = enabled & ~off_q;

  // Standard stepping; a bus error outranks a success pulse
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tec_q <= 9'h000;
      rec_q <= 9'h000;
      off_q <= 1'b0;
    end
    else if (chan_rst)
    begin
      tec_q <= 9'h000;
      rec_q <= 9'h000;
      off_q <= 1'b0;
    end
    else if (count)
    begin
      if (err_tx)
      begin
        if (tec_up >= {1'b0, `CCTE_OFF_LVL})
        begin
          tec_q <= `CCTE_OFF_LVL;
          off_q <= 1'b1;
        end
        else
          tec_q <= tec_up[8:0];
      end
      else if (ok_tx && tec_q != 9'h000)
        tec_q <= tec_q - 9'd1;
      if (err_rx)
      begin
        if (rec_q < `CCTE_PASS_LVL + 9'd8)
          rec_q <= rec_q + 9'd1;
      end
      else if (ok_rx)
      begin
        if (rec_q > `CCTE_PASS_LVL - 9'd1)
          rec_q <= `CCTE_PASS_LVL - 9'd8;
        else if (rec_q != 9'h000)
          rec_q <= rec_q - 9'd1;
      end
    end
  end

  // ****************************************
  // Channel state
  // ****************************************
  wire [8:0] worst = (tec_q > rec_q) ? tec_q : rec_q;
  reg  [2:0] state_d;
  always @*
  begin
    if (~enabled | sleeping)
      state_d = `CCTE_ST_INACTIVE;
    else if (off_q)
      state_d = `CCTE_ST_BUSOFF;
    else if (worst >= `CCTE_PASS_LVL)
      state_d = `CCTE_ST_PASSIVE;
    else if (worst >= `CCTE_WARN_LVL)
      state_d = `CCTE_ST_WARNING;
    else
      state_d = `CCTE_ST_ACTIVE;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= `CCTE_ST_INACTIVE;
    else
      state_q <= state_d;
  end

  // ****************************************
  // Interrupts
  // ****************************************
  wire [2:0] ev;
  assign ev[`CCTE_IRQ_STATE]  = (state_d != state_q);
  assign ev[`CCTE_IRQ_REJECT] = t_rej;
  assign ev[`CCTE_IRQ_BUSOFF] = (state_d == `CCTE_ST_BUSOFF)
                              & (state_q != `CCTE_ST_BUSOFF);
  wire [2:0] clr = (wr & hit_x) ? pwdata[2:0] : 3'h0;

  // Set wins over a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_irq
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          irq_st_q[gi] <= 1'b0;
        else if (ev[gi])
          irq_st_q[gi] <= 1'b1;
        else if (clr[gi])
          irq_st_q[gi] <= 1'b0;
      end
    end
  endgenerate

  assign irq = |(irq_st_q & irq_en_q);

endmodule // ccte_channel

// >>> inc/ccte_map.vh
// Register map, field positions, reset values and timing limits
`ifndef CCTE_MAP_VH
`define CCTE_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define CCTE_OFS_CTRL     12'h000
`define CCTE_OFS_TIMING   12'h004
`define CCTE_OFS_STATUS   12'h008
`define CCTE_OFS_IRQ_STAT 12'h00C
`define CCTE_OFS_IRQ_CLR  12'h010
`define CCTE_OFS_IRQ_EN   12'h014

// ****************************************
// Control bits
// ****************************************
`define CCTE_CTRL_EN     0
`define CCTE_CTRL_SILENT 1
`define CCTE_CTRL_RST    2
`define CCTE_CTRL_SLEEP  3

// ****************************************
// Timing fields, all in quanta or clocks
// ****************************************
`define CCTE_BRP_LSB  0
`define CCTE_PROP_LSB 16
`define CCTE_PH1_LSB  20
`define CCTE_PH2_LSB  24
`define CCTE_SJW_LSB  28
`define CCTE_TIMING_RST 32'h1233_0014
`define CCTE_BRP_MAX  9'd256
`define CCTE_SEG_MAX  4'd8
`define CCTE_PH2_MIN  4'd2
`define CCTE_SJW_MAX  3'd4
`define CCTE_TS1_MIN  5'd4

// ****************************************
// Channel states and thresholds
// ****************************************
`define CCTE_ST_INACTIVE 3'd0
`define CCTE_ST_ACTIVE   3'd1
`define CCTE_ST_WARNING  3'd2
`define CCTE_ST_PASSIVE  3'd3
`define CCTE_ST_BUSOFF   3'd4
`define CCTE_WARN_LVL    9'd96
`define CCTE_PASS_LVL    9'd128
`define CCTE_OFF_LVL     9'd256

// ****************************************
// Interrupt bits and bit rate limits
// ****************************************
`define CCTE_IRQ_STATE  0
`define CCTE_IRQ_REJECT 1
`define CCTE_IRQ_BUSOFF 2
`define CCTE_CLK_HZ     200000000
`define CCTE_RATE_MAX   1000000
`define CCTE_RATE_MIN   5000
`define CCTE_CYC_MIN    (`CCTE_CLK_HZ / `CCTE_RATE_MAX)
`define CCTE_CYC_MAX    (`CCTE_CLK_HZ / `CCTE_RATE_MIN)

`endif

// >>> test/ccte_bus_node.sv
// Model of the other nodes that share the CAN bus with the channel
`timescale 1ns/1ps
// ****************************************
// Bus node model
// ****************************************
module ccte_bus_node
(
  input  wire can_tx,
  input  wire hold_dom,
  output wire can_rx
);
  // Wired-AND bus: a dominant 0 from any node beats recessive
  assign can_rx = can_tx & ~hold_dom;
endmodule // ccte_bus_node

// >>> test/ccte_channel_checker.sv
// Port checker for the CAN channel core
`timescale 1ns/1ps
// ****************************************
// Checker
// ****************************************
module ccte_channel_checker
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        can_tx,
  input wire        sample_q,
  input wire        bit_start_q,
  input wire        irq
);
  logic [3:0] ctrl_q;
  // Shadow of the control word; the pin rules hang on it
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      ctrl_q <= 4'h0;
    else if (psel && penable && pwrite && paddr == 12'h000)
      ctrl_q <= pwdata[3:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_zero_wait; psel |-> pready; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("wait state seen");
  property p_unmapped;
    psel && penable && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 12'h014);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad slave error");
  property p_rd_idle;
    !(psel && penable && !pwrite) |-> prdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data leaks");
  property p_silent; ctrl_q[1] |=> can_tx; endproperty
  a_silent: assert property (p_silent) else $error("silent drove bus");
  property p_idle_pin; !ctrl_q[0] || ctrl_q[3] |=> can_tx; endproperty
  a_idle_pin: assert property (p_idle_pin) else $error("idle drove bus");
  property p_sample_gap; sample_q |=> !sample_q [*8]; endproperty
  a_sample_gap: assert property (p_sample_gap) else $error("sample gap");
  property p_start_gap; bit_start_q |=> !bit_start_q [*8]; endproperty
  a_start_gap: assert property (p_start_gap) else $error("bit too short");
  property p_apart; sample_q |-> !bit_start_q; endproperty
  a_apart: assert property (p_apart) else $error("sample at bit start");
  property p_mask;
    psel && penable && pwrite && paddr == 12'h014 && pwdata == 32'h0 |=> !irq;
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq high");
endmodule // ccte_channel_checker

// >>> test/ccte_channel_tb.sv
// Self-checking bench for the CAN channel core
`timescale 1ns/1ps
// ****************************************
// Bench top
// ****************************************
module ccte_channel_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, se, can_rx, can_tx, rx_bit_q;
  logic        tx_bit = 1, ack_req = 0, hold_dom = 0;
  logic        sample_q, bit_start_q, irq;
  logic [3:0]  ev = 0;
  int          errors = 0, n_compared = 0;
  always #2.5 pclk = ~pclk;
  ccte_channel i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .can_rx, .can_tx, .tx_bit,
    .ack_req, .err_tx(ev[0]), .err_rx(ev[1]), .ok_tx(ev[2]), .ok_rx(ev[3]),
    .rx_bit_q, .sample_q, .bit_start_q, .irq);
  ccte_bus_node i_node (.can_tx, .hold_dom, .can_rx);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1)
      errors++;
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] tm(input int b, p, f, s, j);
    tm = {1'b0, j[2:0], s[3:0], f[3:0], p[3:0], 7'h00, b[8:0]};
  endfunction
  task automatic st(input logic [3:0] exp);
    apb(0, 12'h008, 0);
    chk(rd[3:0], exp);
  endtask
  task automatic ck_irq(input logic exp);
    @(negedge pclk);
    chk(irq, exp);
  endtask
  task automatic pulse(input int b, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      ev[b] <= 1'b1;
      @(posedge pclk);
      ev[b] <= 1'b0;
    end
  endtask
  // Skips the partial bit after a change and the next whole bit, then times one whole bit
  task automatic meas(output int per, output int off);
    int c;
    repeat (2)
    begin
      @(negedge pclk);
      c = 0;
      while (bit_start_q !== 1'b1 && c < 3000)
      begin
        @(negedge pclk);
        c++;
      end
    end
    off = 0;
    c = 0;
    do
    begin
      @(negedge pclk);
      c++;
      if (sample_q === 1'b1)
        off = c;
    end
    while (bit_start_q !== 1'b1 && c < 3000);
    if (c >= 3000)
      errors++;
    per = c;
  endtask
  task automatic t_regs;
    apb(0, 12'h004, 0);
    chk(rd, 32'h1233_0014);
    apb(0, 12'h100, 0);
    chk({rd[31:1], se}, 32'h0000_0001);
    apb(1, 12'h014, 32'h0000_0007);
    apb(0, 12'h014, 0);
    chk(rd, 32'h0000_0007);
    apb(1, 12'h014, 32'h0000_0000);
  endtask
  task automatic t_timing;
    logic [31:0] bad [12];
    bad = '{tm(0,8,8,4,4), tm(257,8,8,4,4), tm(10,0,8,4,4), tm(10,9,8,4,4),
      tm(10,8,0,4,4), tm(10,8,9,4,4), tm(10,8,8,1,4), tm(10,8,8,9,4),
      tm(10,8,8,4,0), tm(10,8,8,4,5), tm(40,1,2,8,4), tm(1,8,8,8,4)};
    apb(1, 12'h004, tm(256,8,8,8,4));
    apb(0, 12'h004, 0);
    chk(rd, tm(256,8,8,8,4));
    foreach (bad[i])
    begin
      apb(1, 12'h004, bad[i]);
      apb(0, 12'h004, 0);
      chk(rd, tm(256,8,8,8,4));
      apb(0, 12'h00C, 0);
      chk(rd & 32'h2, 32'h2);
      apb(1, 12'h010, 32'h0000_0002);
    end
    apb(0, 12'h00C, 0);
    chk(rd & 32'h2, 32'h0);
    apb(1, 12'h004, tm(40,1,3,2,1));
    apb(0, 12'h004, 0);
    chk(rd, tm(40,1,3,2,1));
  endtask
  task automatic t_bits;
    int p, o, o0;
    apb(1, 12'h000, 32'h0000_0001);
    apb(1, 12'h004, tm(10,8,8,4,1));
    meas(p, o0);
    chk(p, 210);
    apb(1, 12'h004, tm(10,8,8,4,4));
    meas(p, o);
    chk(p, 210);
    chk(o, o0);
    apb(1, 12'h004, tm(10,4,8,8,1));
    meas(p, o);
    chk(o, o0 - 40);
    apb(1, 12'h004, tm(20,8,8,2,1));
    meas(p, o);
    chk(p, 380);
    chk(o, o0 + 170);
    @(posedge pclk);
    hold_dom <= 1'b1;
    meas(p, o);
    chk(rx_bit_q, 1'b0);
    @(posedge pclk);
    hold_dom <= 1'b0;
    meas(p, o);
    chk(rx_bit_q, 1'b1);
  endtask
  task automatic t_silent;
    apb(1, 12'h000, 32'h0000_0003);
    tx_bit <= 1'b0;
    ack_req <= 1'b1;
    repeat (4) @(negedge pclk);
    chk(can_tx, 1'b1);
    apb(1, 12'h000, 32'h0000_0001);
    repeat (3) @(negedge pclk);
    chk(can_tx, 1'b0);
    @(posedge pclk);
    tx_bit <= 1'b1;
    ack_req <= 1'b0;
  endtask
  // Walks the counter thresholds, then bus off and its recovery
  task automatic t_state;
    apb(1, 12'h010, 32'h0000_0007);
    apb(1, 12'h014, 32'h0000_0004);
    st(4'h1);
    pulse(1, 95);
    st(4'h1);
    pulse(1, 1);
    st(4'h2);
    pulse(1, 32);
    st(4'h3);
    pulse(3, 1);
    st(4'h2);
    ck_irq(1'b0);
    pulse(0, 31);
    st(4'h3);
    pulse(0, 1);
    st(4'hC);
    pulse(2, 5);
    st(4'hC);
    apb(0, 12'h00C, 0);
    chk(rd, 32'h0000_0005);
    ck_irq(1'b1);
    apb(1, 12'h014, 32'h0000_0000);
    ck_irq(1'b0);
    apb(1, 12'h014, 32'h0000_0004);
    ck_irq(1'b1);
    apb(1, 12'h010, 32'h0000_0004);
    ck_irq(1'b0);
    apb(1, 12'h000, 32'h0000_0005);
    st(4'h1);
    apb(1, 12'h000, 32'h0000_0009);
    st(4'h0);
    apb(1, 12'h000, 32'h0000_0000);
    st(4'h0);
  endtask
  task automatic close_out;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_timing;
    t_bits;
    t_silent;
    t_state;
    close_out;
  end
  // Watchdog at 60000 cycles, well beyond the expected six thousand
  initial
  begin
    #300000;
    errors++;
    close_out;
  end
endmodule // ccte_channel_tb
bind ccte_channel ccte_channel_checker i_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .can_tx,
  .sample_q, .bit_start_q, .irq);
